// file: rtl/nvmc_map.svh
// offsets, field positions, reset values and timing counts of the nvm command block
`ifndef NVMC_MAP_SVH
`define NVMC_MAP_SVH

// register byte offsets
`define NVMC_OFF_CLKDIV 8'h00
`define NVMC_OFF_STATUS 8'h01
`define NVMC_OFF_INDEX 8'h02
`define NVMC_OFF_INTST 8'h03
`define NVMC_OFF_INTMASK 8'h04
`define NVMC_OFF_PROTECT 8'h05
`define NVMC_OFF_PARAM 8'h10
`define NVMC_OFF_PARAM_END 8'h1B

// divider register fields
`define NVMC_DIV_LOADED_BIT 7
`define NVMC_DIV_LOCK_BIT 6
`define NVMC_DIV_RESET 6'h00

// command status register fields
`define NVMC_ST_COMMAND_COMPLETE_FLAG_BIT 7
`define NVMC_ST_ACCESS_ERROR_FLAG_BIT 5
`define NVMC_ST_PROTECTION_VIOLATION_FLAG_BIT 4
`define NVMC_ST_MGS1_BIT 1
`define NVMC_ST_MGS0_BIT 0

// interrupt status and mask fields
`define NVMC_INT_DONE_BIT 0
`define NVMC_INT_ACC_BIT 1
`define NVMC_INT_PV_BIT 2
`define NVMC_INT_RESET 3'h0

// other reset values
`define NVMC_IDX_RESET 3'h0
`define NVMC_PROT_RESET 4'h0

// command codes and index limits
`define NVMC_CMD_PROGRAM 8'h11
`define NVMC_CMD_ERASE 8'h12
`define NVMC_IDX_PROG_MIN 3'h2
`define NVMC_IDX_PROG_MAX 3'h5
`define NVMC_IDX_ERASE 3'h1
`define NVMC_WORD_FIRST_DATA 3'h2

// eeprom window, sector of four bytes
`define NVMC_EE_BASE 24'h100000
`define NVMC_EE_LAST 24'h1003FF
`define NVMC_SECTOR_MASK 24'hFFFFFC
`define NVMC_WORD_STEP 24'h000002

// timing, in microseconds of the 1 MHz tick
`define NVMC_TICK_MHZ 1
`define NVMC_ERASE_TIME_US 20
`define NVMC_PROG_TIME_US 40
`define NVMC_ERASE_TICKS 8'(`NVMC_ERASE_TIME_US * `NVMC_TICK_MHZ)
`define NVMC_PROG_TICKS 8'(`NVMC_PROG_TIME_US * `NVMC_TICK_MHZ)

`endif

// file: rtl/nvmc_pkg.sv
// types of the nvm command block
package nvmc_pkg;

	// command sequencer states
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_FETCH0,
		ST_FETCH1,
		ST_GETLO,
		ST_CHECK,
		ST_ERASE,
		ST_PFETCH,
		ST_PLOAD,
		ST_PROG,
		ST_VERIFY,
		ST_VWAIT,
		ST_DONE
	} nvmc_state_t;

	// whole state of the top module
	typedef struct packed {
		nvmc_state_t st;
		logic [5:0] dividerValue;
		logic dividerLock;
		logic dividerLoaded;
		logic [5:0] divCnt;
		logic tick;
		logic command_complete_flag;
		logic access_error_flag;
		logic protViol;
		logic verErr;
		logic verUnc;
		logic [2:0] paramIdx;
		logic [3:0] protect;
		logic [2:0] intSt;
		logic [2:0] intMask;
		logic irq;
		logic rdMem;
		logic rdLow;
		logic [7:0] rdReg;
		logic [7:0] cmd;
		logic [23:0] addr;
		logic [23:0] lastAddr;
		logic [2:0] wordPtr;
		logic [7:0] tickLeft;
		logic arrErase;
		logic arrProg;
		logic arrVerify;
		logic [23:0] arrAddr;
		logic [15:0] arrData;
	} nvmc_regs_t;

	// state of the parameter memory
	typedef struct packed {
		logic [5:0][15:0] words;
		logic [15:0] busQ;
		logic [15:0] ctrlQ;
	} nvmc_ram_t;

endpackage

// file: rtl/nvmc_param_ram.sv
// six-word parameter memory with byte writes and two registered read ports
`timescale 1ns/100ps
module nvmc_param_ram (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// byte write port
	input wire logic writeEn,
	input wire logic [2:0] writeWord,
	input wire logic writeHigh,
	input wire logic [7:0] writeByte,
	// bus read port
	input wire logic [2:0] busWord,
	output logic [15:0] busData,
	// sequencer read port
	input wire logic [2:0] ctrlWord,
	output logic [15:0] ctrlData
);
	nvmc_pkg::nvmc_ram_t r;
	nvmc_pkg::nvmc_ram_t n;

	// byte lanes written separately, reads always registered
	always_comb begin
		n = r;
		for (int i = 0; i < 6; i++) begin
			if (writeEn && writeWord == 3'(i)) begin
				if (writeHigh) begin
					n.words[i][15:8] = writeByte;
				end else begin
					n.words[i][7:0] = writeByte;
				end
			end
		end
		// out-of-range words read as zero
		n.busQ = (busWord < 3'h6) ? r.words[busWord] : 16'h0000;
		n.ctrlQ = (ctrlWord < 3'h6) ? r.words[ctrlWord] : 16'h0000;
	end

	// register the copy
	always_ff @(posedge mclk) begin
		if (reset) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign busData = r.busQ;
	assign ctrlData = r.ctrlQ;
endmodule // nvmc_param_ram

// file: rtl/nvmc_top.sv
// nvm clock divider, parameter array and eeprom program / erase sequencer
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/100ps
`include "nvmc_map.svh"
module nvmc_top (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// register port
	input wire logic [7:0] busAddr,
	input wire logic [7:0] busWdata,
	input wire logic busWrite,
	input wire logic busRead,
	output logic [7:0] busRdata,
	// mode
	input wire logic cmdAllowedMode,
	// memory array side
	output logic arrayErase,
	output logic arrayProgram,
	output logic arrayVerify,
	output logic [23:0] arrayAddr,
	output logic [15:0] arrayWdata,
	input wire logic verifyError,
	input wire logic verifyUncorrectable,
	// status outputs
	output logic nvmTick,
	output logic commandCompleteFlag,
	output logic irq
);
	nvmc_pkg::nvmc_regs_t r;
	nvmc_pkg::nvmc_regs_t n;

	// parameter memory wiring
	logic paramHit;
	logic [7:0] paramOff;
	logic [2:0] ctrlWord;
	logic [15:0] memBus;
	logic [15:0] memCtrl;
	// launch-time checks
	logic isProg;
	logic isErase;
	logic [2:0] idxLess2;
	logic [23:0] progLast;
	logic [23:0] sectStart;
	logic [23:0] sectLast;
	logic launchAcc;
	logic launchPv;
	// events of this cycle
	logic evDone;
	logic evAcc;
	logic evPv;

	// address inside the eeprom window
	function automatic logic inEeprom(input logic [23:0] a);
		inEeprom = (a >= `NVMC_EE_BASE) && (a <= `NVMC_EE_LAST);
	endfunction

	// protection quarter of an eeprom address
	function automatic logic [1:0] eeQuarter(input logic [23:0] a);
		logic [23:0] off;
		off = a - `NVMC_EE_BASE;
		eeQuarter = off[9:8];
	endfunction

	// byte address to parameter word
	assign paramOff = busAddr - `NVMC_OFF_PARAM;
	assign paramHit = (busAddr >= `NVMC_OFF_PARAM) && (busAddr <= `NVMC_OFF_PARAM_END);

	// sequencer read address follows the current state
	always_comb begin
		case (r.st)
			nvmc_pkg::ST_FETCH0: ctrlWord = 3'h0;
			nvmc_pkg::ST_FETCH1: ctrlWord = 3'h1;
			default: ctrlWord = r.wordPtr;
		endcase
	end

	// parameter words, written only while no command runs
	nvmc_param_ram u_ram (
		.mclk(mclk),
		.reset(reset),
		.writeEn(busWrite && paramHit && r.command_complete_flag),
		.writeWord(paramOff[3:1]),
		.writeHigh(~paramOff[0]),
		.writeByte(busWdata),
		.busWord(paramOff[3:1]),
		.busData(memBus),
		.ctrlWord(ctrlWord),
		.ctrlData(memCtrl)
	);

	// error decoding on the fetched command
	assign isProg = (r.cmd == `NVMC_CMD_PROGRAM);
	assign isErase = (r.cmd == `NVMC_CMD_ERASE);
	assign idxLess2 = r.paramIdx - `NVMC_WORD_FIRST_DATA;
	// last programmed word: one word per index step above word 2
	assign progLast = r.addr + {20'h00000, idxLess2, 1'b0};
	assign sectStart = r.addr & `NVMC_SECTOR_MASK;
	// last word of the sector: start with the in-sector word bits set, byte bit clear
	assign sectLast = sectStart | (~`NVMC_SECTOR_MASK & ~(`NVMC_WORD_STEP - 24'h000001));

	always_comb begin
		// command unknown or not allowed in this mode
		launchAcc = !(isProg || isErase) || !cmdAllowedMode;
		// start address outside the window, or odd
		if (!inEeprom(r.addr) || r.addr[0]) begin
			launchAcc = 1'b1;
		end
		if (isProg) begin
			if (r.paramIdx < `NVMC_IDX_PROG_MIN || r.paramIdx > `NVMC_IDX_PROG_MAX) begin
				launchAcc = 1'b1;
			end else if (!inEeprom(progLast)) begin
				launchAcc = 1'b1;
			end
		end
		launchAcc = launchAcc | (isErase && r.paramIdx != `NVMC_IDX_ERASE);
		// protection judged only on addresses already in range
		launchPv = r.protect[eeQuarter(r.addr)];
		if (isProg && inEeprom(progLast)) begin
			launchPv = launchPv | r.protect[eeQuarter(progLast)];
		end
		launchPv = launchPv & !launchAcc;
	end

	// next-state logic
	always_comb begin
		n = r;
		evDone = 1'b0;
		evAcc = 1'b0;
		evPv = 1'b0;
		n.arrVerify = 1'b0;

		// divide the bus clock by value plus one; no range check on the result
		if (r.divCnt >= r.dividerValue) begin
			n.divCnt = 6'h00;
			n.tick = 1'b1;
		end else begin
			n.divCnt = r.divCnt + 6'h01;
			n.tick = 1'b0;
		end

		// register writes
		if (busWrite) begin
			case (busAddr)
				`NVMC_OFF_CLKDIV: begin
					// a write while busy is taken as is, software avoids it
					n.dividerLoaded = 1'b1;
					if (!r.dividerLock) begin
						n.dividerValue = busWdata[5:0];
						n.dividerLock = busWdata[`NVMC_DIV_LOCK_BIT];
					end
				end
				`NVMC_OFF_STATUS: begin
					// errors clear by writing one
					n.access_error_flag = r.access_error_flag & !busWdata[`NVMC_ST_ACCESS_ERROR_FLAG_BIT];
					n.protViol = r.protViol & !busWdata[`NVMC_ST_PROTECTION_VIOLATION_FLAG_BIT];
					// launch needs both old errors cleared beforehand
					if (busWdata[`NVMC_ST_COMMAND_COMPLETE_FLAG_BIT] && r.command_complete_flag && !r.access_error_flag
						&& !r.protViol && r.st == nvmc_pkg::ST_IDLE) begin
						n.command_complete_flag = 1'b0;
						n.verErr = 1'b0;
						n.verUnc = 1'b0;
						n.st = nvmc_pkg::ST_FETCH0;
					end
				end
				`NVMC_OFF_INDEX: begin
					n.paramIdx = r.command_complete_flag ? busWdata[2:0] : r.paramIdx;
				end
				`NVMC_OFF_INTMASK: n.intMask = busWdata[2:0];
				`NVMC_OFF_PROTECT: begin
					n.protect = r.command_complete_flag ? busWdata[3:0] : r.protect;
				end
				default: begin
					// parameter bytes go to the memory, others ignored
				end
			endcase
		end

		// reads: data in the following cycle only
		n.rdMem = busRead && paramHit;
		n.rdLow = paramOff[0];
		n.rdReg = 8'h00;
		if (busRead) begin
			case (busAddr)
				`NVMC_OFF_CLKDIV: begin
					n.rdReg = {r.dividerLoaded, r.dividerLock, r.dividerValue};
				end
				`NVMC_OFF_STATUS: begin
					n.rdReg[`NVMC_ST_COMMAND_COMPLETE_FLAG_BIT] = r.command_complete_flag;
					n.rdReg[`NVMC_ST_ACCESS_ERROR_FLAG_BIT] = r.access_error_flag;
					n.rdReg[`NVMC_ST_PROTECTION_VIOLATION_FLAG_BIT] = r.protViol;
					n.rdReg[`NVMC_ST_MGS1_BIT] = r.verErr;
					n.rdReg[`NVMC_ST_MGS0_BIT] = r.verUnc;
				end
				`NVMC_OFF_INDEX: n.rdReg = {5'h00, r.paramIdx};
				`NVMC_OFF_INTST: begin
					n.rdReg = {5'h00, r.intSt};
					// read clears; events below still win
					n.intSt = 3'h0;
				end
				`NVMC_OFF_INTMASK: n.rdReg = {5'h00, r.intMask};
				`NVMC_OFF_PROTECT: n.rdReg = {4'h0, r.protect};
				default: n.rdReg = 8'h00;
			endcase
		end

		// command sequencer
		case (r.st)
			nvmc_pkg::ST_IDLE: begin
				// waiting for launch
			end
			nvmc_pkg::ST_FETCH0: n.st = nvmc_pkg::ST_FETCH1;
			nvmc_pkg::ST_FETCH1: begin
				// word 0: code and address high byte
				n.cmd = memCtrl[15:8];
				n.addr[23:16] = memCtrl[7:0];
				n.st = nvmc_pkg::ST_GETLO;
			end
			nvmc_pkg::ST_GETLO: begin
				// word 1: address low half
				n.addr[15:0] = memCtrl;
				n.st = nvmc_pkg::ST_CHECK;
			end
			nvmc_pkg::ST_CHECK: begin
				if (launchAcc || launchPv) begin
					// no array activity on a bad launch
					evAcc = launchAcc;
					evPv = launchPv;
					n.st = nvmc_pkg::ST_DONE;
				end else if (isErase) begin
					// whole sector erased, then each word verified
					n.arrAddr = sectStart;
					n.lastAddr = sectLast;
					n.arrErase = 1'b1;
					n.tickLeft = `NVMC_ERASE_TICKS;
					n.st = nvmc_pkg::ST_ERASE;
				end else begin
					n.arrAddr = r.addr;
					n.lastAddr = progLast;
					n.wordPtr = `NVMC_WORD_FIRST_DATA;
					n.st = nvmc_pkg::ST_PFETCH;
				end
			end
			nvmc_pkg::ST_ERASE: begin
				// erase pulse timed in divider ticks
				if (r.tick) begin
					n.tickLeft = r.tickLeft - 8'h01;
					if (r.tickLeft <= 8'h01) begin
						n.arrErase = 1'b0;
						n.arrAddr = r.arrAddr & `NVMC_SECTOR_MASK;
						n.st = nvmc_pkg::ST_VERIFY;
					end
				end
			end
			nvmc_pkg::ST_PFETCH: n.st = nvmc_pkg::ST_PLOAD;
			nvmc_pkg::ST_PLOAD: begin
				n.arrData = memCtrl;
				n.arrProg = 1'b1;
				n.tickLeft = `NVMC_PROG_TICKS;
				n.st = nvmc_pkg::ST_PROG;
			end
			nvmc_pkg::ST_PROG: begin
				if (r.tick) begin
					n.tickLeft = r.tickLeft - 8'h01;
					if (r.tickLeft <= 8'h01) begin
						n.arrProg = 1'b0;
						if (r.wordPtr >= r.paramIdx) begin
							// all words written, verify from the start
							n.arrAddr = r.addr;
							n.st = nvmc_pkg::ST_VERIFY;
						end else begin
							n.wordPtr = r.wordPtr + 3'h1;
							n.arrAddr = r.arrAddr + `NVMC_WORD_STEP;
							n.st = nvmc_pkg::ST_PFETCH;
						end
					end
				end
			end
			nvmc_pkg::ST_VERIFY: begin
				n.arrVerify = 1'b1;
				n.st = nvmc_pkg::ST_VWAIT;
			end
			nvmc_pkg::ST_VWAIT: begin
				// result sampled while the verify strobe is high
				n.verErr = r.verErr | verifyError | verifyUncorrectable;
				n.verUnc = r.verUnc | verifyUncorrectable;
				if (r.arrAddr >= r.lastAddr) begin
					n.st = nvmc_pkg::ST_DONE;
				end else begin
					n.arrAddr = r.arrAddr + `NVMC_WORD_STEP;
					n.st = nvmc_pkg::ST_VERIFY;
				end
			end
			nvmc_pkg::ST_DONE: begin
				n.command_complete_flag = 1'b1;
				evDone = 1'b1;
				n.st = nvmc_pkg::ST_IDLE;
			end
			default: n.st = nvmc_pkg::ST_IDLE;
		endcase

		// hardware sets win over software clears
		n.access_error_flag = n.access_error_flag | evAcc;
		n.protViol = n.protViol | evPv;
		n.intSt[`NVMC_INT_DONE_BIT] = n.intSt[`NVMC_INT_DONE_BIT] | evDone;
		n.intSt[`NVMC_INT_ACC_BIT] = n.intSt[`NVMC_INT_ACC_BIT] | evAcc;
		n.intSt[`NVMC_INT_PV_BIT] = n.intSt[`NVMC_INT_PV_BIT] | evPv;
		n.irq = |(n.intSt & n.intMask);
	end

	// register the copy; lock and loaded clear only here
	always_ff @(posedge mclk) begin
		if (reset) begin
			r <= '0;
			r.st <= nvmc_pkg::ST_IDLE;
			r.dividerValue <= `NVMC_DIV_RESET;
			r.command_complete_flag <= 1'b1;
			r.paramIdx <= `NVMC_IDX_RESET;
			r.protect <= `NVMC_PROT_RESET;
			r.intMask <= `NVMC_INT_RESET;
			r.intSt <= `NVMC_INT_RESET;
		end else begin
			r <= n;
		end
	end

	// outputs; read data muxed between two registered sources
	assign busRdata = r.rdMem ? (r.rdLow ? memBus[7:0] : memBus[15:8]) : r.rdReg;
	assign arrayErase = r.arrErase;
	assign arrayProgram = r.arrProg;
	assign arrayVerify = r.arrVerify;
	assign arrayAddr = r.arrAddr;
	assign arrayWdata = r.arrData;
	assign nvmTick = r.tick;
	assign commandCompleteFlag = r.command_complete_flag;
	assign irq = r.irq;
endmodule // nvmc_top

// file: tb/nvmc_top_props.sv
// port assertions of the nvm command block
`timescale 1ns/100ps
`include "nvmc_map.svh"
module nvmc_top_props (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// register port
	input wire logic [7:0] busAddr,
	input wire logic [7:0] busWdata,
	input wire logic busWrite,
	input wire logic busRead,
	input wire logic [7:0] busRdata,
	// array side and status
	input wire logic arrayErase,
	input wire logic arrayProgram,
	input wire logic arrayVerify,
	input wire logic [23:0] arrayAddr,
	input wire logic nvmTick,
	input wire logic commandCompleteFlag
);
	logic [5:0] divS_r; // divider field as software left it
	logic lockS_r; // lock shadow
	logic loadS_r; // loaded shadow
	logic [5:0] gap_r; // cycles since the last tick
	logic [6:0] quiet_r; // cycles since a divider write, saturating
	logic divWr;
	assign divWr = busWrite && busAddr == `NVMC_OFF_CLKDIV;
	// shadow of the divider register, built from bus writes alone
	always_ff @(posedge mclk) begin
		if (reset) begin
			divS_r <= 6'h00;
			lockS_r <= 1'b0;
			loadS_r <= 1'b0;
			gap_r <= 6'h00;
			quiet_r <= 7'h00;
		end else begin
			if (divWr && !lockS_r) begin
				divS_r <= busWdata[5:0];
			end
			lockS_r <= lockS_r | (divWr & busWdata[`NVMC_DIV_LOCK_BIT]);
			loadS_r <= loadS_r | divWr;
			gap_r <= nvmTick ? 6'h00 : gap_r + 6'h01;
			// the tick phase after a ratio change is left open, so wait it out
			quiet_r <= divWr ? 7'h00 : (quiet_r == 7'h7F ? quiet_r : quiet_r + 7'h01);
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	// launch write while idle
	sequence sLaunch;
		busWrite && busAddr == `NVMC_OFF_STATUS && busWdata[`NVMC_ST_COMMAND_COMPLETE_FLAG_BIT] && commandCompleteFlag;
	endsequence
	// busy for at least the fetch cycles
	sequence sBusy;
		!commandCompleteFlag [*2];
	endsequence
	a_launch_busy: assert property (sLaunch |=> sBusy)
		else $error("complete flag did not drop after launch");
	a_erase_sector: assert property ($rose(arrayErase) |-> arrayAddr[1:0] == 2'b00
		&& arrayAddr >= `NVMC_EE_BASE && arrayAddr <= `NVMC_EE_LAST)
		else $error("erase address not a sector start");
	a_array_busy: assert property ((arrayErase || arrayProgram || arrayVerify)
		|-> !commandCompleteFlag) else $error("array active while complete");
	a_one_op: assert property (arrayErase |-> !arrayProgram)
		else $error("erase and program together");
	a_word_aligned: assert property ((arrayProgram || arrayVerify) |-> !arrayAddr[0])
		else $error("odd array word address");
	a_prog_window: assert property (arrayProgram |-> arrayAddr >= `NVMC_EE_BASE
		&& arrayAddr <= `NVMC_EE_LAST) else $error("program outside eeprom");
	a_div_readback: assert property (busRead && busAddr == `NVMC_OFF_CLKDIV
		|=> busRdata == {loadS_r, lockS_r, divS_r}) else $error("divider read wrong");
	a_tick_rate: assert property (nvmTick && quiet_r == 7'h7F |-> gap_r == divS_r)
		else $error("tick spacing wrong");
	a_verify_pulse: assert property (arrayVerify |=> !arrayVerify)
		else $error("verify strobe longer than one cycle");
endmodule // nvmc_top_props

bind nvmc_top nvmc_top_props u_nvmc_top_props (.mclk(mclk), .reset(reset),
	.busAddr(busAddr), .busWdata(busWdata), .busWrite(busWrite), .busRead(busRead),
	.busRdata(busRdata), .arrayErase(arrayErase), .arrayProgram(arrayProgram),
	.arrayVerify(arrayVerify), .arrayAddr(arrayAddr), .nvmTick(nvmTick),
	.commandCompleteFlag(commandCompleteFlag));

// file: tb/nvmc_top_tb.sv
// self-checking bench of the nvm command block
`timescale 1ns/100ps
`include "nvmc_map.svh"
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin n_mismatch++; \
	$display("Error %s expected %h seen %h", nm, e, s); end end
module nvmc_top_tb;
	// design ports
	logic mclk, reset, busWrite, busRead, cmdAllowedMode, verifyError, verifyUncorrectable;
	logic [7:0] busAddr, busWdata, busRdata;
	logic arrayErase, arrayProgram, arrayVerify, nvmTick, commandCompleteFlag, irq;
	logic [23:0] arrayAddr;
	logic [15:0] arrayWdata;
	// counters and scratch
	int n_mismatch = 0;
	int comparisons = 0;
	int n;
	logic [31:0] seed = 32'h8374;
	logic [7:0] pb [12];
	logic [7:0] c, st, rv;
	logic [23:0] a, eraseAt;
	logic [15:0] wd; // last word seen on the program data bus
	logic [2:0] ix;
	logic [3:0] p;
	logic [5:0] dv;
	logic m;
	// corner commands run before the random ones
	logic [7:0] cC [8] = '{8'h12, 8'h12, 8'h11, 8'h11, 8'h11, 8'h12, 8'h12, 8'h12};
	logic [23:0] cA [8] = '{24'h100006, 24'h100005, 24'h1003FE, 24'h100010, 24'h100010,
		24'h100100, 24'h100200, 24'h100100};
	logic [2:0] cI [8] = '{3'h1, 3'h1, 3'h3, 3'h6, 3'h1, 3'h0, 3'h1, 3'h1};
	nvmc_top u_nvmc_top (.mclk(mclk), .reset(reset), .busAddr(busAddr), .busWdata(busWdata),
		.busWrite(busWrite), .busRead(busRead), .busRdata(busRdata),
		.cmdAllowedMode(cmdAllowedMode), .arrayErase(arrayErase), .arrayProgram(arrayProgram),
		.arrayVerify(arrayVerify), .arrayAddr(arrayAddr), .arrayWdata(arrayWdata),
		.verifyError(verifyError), .verifyUncorrectable(verifyUncorrectable),
		.nvmTick(nvmTick), .commandCompleteFlag(commandCompleteFlag), .irq(irq));
	// 40 MHz clock
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// xorshift source, fixed start
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// status after a command, verify bits left out
	function automatic logic [7:0] expStat(input logic [7:0] cd, input logic [23:0] ad,
		input logic [2:0] ixv, input logic md, input logic [3:0] pr);
		logic [23:0] last;
		logic acc;
		last = ad + 24'(2 * (int'(ixv) - 2));
		acc = !md || ad < `NVMC_EE_BASE || ad > `NVMC_EE_LAST || ad[0];
		if (cd == `NVMC_CMD_PROGRAM)
			acc = acc || ixv < 3'h2 || ixv > 3'h5 || last > `NVMC_EE_LAST;
		else
			acc = acc || ixv != 3'h1 || cd != `NVMC_CMD_ERASE;
		if (acc)
			return 8'hA0;
		if (pr[ad[9:8]] || (cd == `NVMC_CMD_PROGRAM && pr[last[9:8]]))
			return 8'h90;
		return 8'h80;
	endfunction
	// one write cycle
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge mclk);
		busAddr <= ad;
		busWdata <= d;
		busWrite <= 1'b1;
		@(posedge mclk);
		busWrite <= 1'b0;
	endtask
	// one read cycle, data taken in the following cycle
	task automatic chkRd(input logic [7:0] ad, input logic [7:0] e, input string nm);
		@(posedge mclk);
		busAddr <= ad;
		busRead <= 1'b1;
		@(posedge mclk);
		busRead <= 1'b0;
		@(negedge mclk);
		rv = busRdata;
		`CHK(nm, e, rv)
	endtask
	// synchronous reset for twelve cycles
	task automatic doReset();
		reset <= 1'b1;
		repeat (12) @(posedge mclk);
		reset <= 1'b0;
	endtask
	// verdict and end of run
	task automatic tally_and_finish();
		if (n_mismatch == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// watchdog, the run needs about 3000 cycles
	initial begin
		repeat (60000) @(posedge mclk);
		n_mismatch++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		{busWrite, busRead, busAddr, busWdata, reset} = 19'h00001;
		{cmdAllowedMode, verifyError, verifyUncorrectable} = 3'b100;
		doReset();
		chkRd(8'h00, 8'h00, "divider");
		dv = 6'(rnd() % 63 + 1);
		wr(8'h00, {2'b00, dv}); // idle here, never written while busy
		chkRd(8'h00, {2'b10, dv}, "divider");
		// time one tick gap once the ratio has settled
		repeat (130) @(posedge mclk);
		n = 0;
		do @(negedge mclk); while (nvmTick !== 1'b1 && ++n < 70);
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (nvmTick !== 1'b1 && n < 70);
		`CHK("tick gap", int'(dv) + 1, n)
		// lock then try to move the field
		wr(8'h00, {2'b01, dv});
		wr(8'h00, {2'b00, ~dv});
		chkRd(8'h00, {2'b11, dv}, "divider");
		doReset();
		chkRd(8'h00, 8'h00, "divider");
		// parameter bytes one by one
		for (int k = 0; k < 12; k++) begin
			pb[k] = 8'(rnd());
			wr(8'(`NVMC_OFF_PARAM + k), pb[k]);
		end
		for (int k = 0; k < 12; k++) chkRd(8'(`NVMC_OFF_PARAM + k), pb[k], "param");
		wr(8'h04, 8'h07);
		// commands; divider 0 is out of range yet must still run
		for (int i = 0; i < 32; i++) begin
			if (i < 8) begin
				c = cC[i];
				a = cA[i];
				ix = cI[i];
				m = i != 7;
				p = (i == 6) ? 4'h4 : 4'h0;
			end else begin
				c = (rnd() % 2) ? `NVMC_CMD_PROGRAM : `NVMC_CMD_ERASE;
				// now and then a code the sequencer does not know
				if (rnd() % 9 == 0) c = 8'(rnd());
				a = `NVMC_EE_BASE + 24'(rnd() & 32'h3FE);
				if (rnd() % 6 == 0) a = a ^ 24'(rnd());
				ix = (c == `NVMC_CMD_ERASE) ? 3'h1 : 3'(rnd() % 4 + 2);
				if (rnd() % 5 == 0) ix = 3'(rnd());
				m = rnd() % 8 != 0;
				p = 4'(rnd() & rnd());
			end
			cmdAllowedMode <= m;
			verifyError <= rnd() % 3 == 0;
			verifyUncorrectable <= rnd() % 4 == 0;
			for (int k = 0; k < 12; k++) begin
				pb[k] = k == 0 ? c : (k < 4 ? 8'(a >> (24 - 8 * k)) : 8'(rnd()));
				wr(8'(`NVMC_OFF_PARAM + k), pb[k]);
			end
			wr(8'h02, {5'h00, ix});
			wr(8'h05, {4'h0, p});
			st = expStat(c, a, ix, m, p);
			if (st == 8'h80) st = st | {6'h00, verifyError | verifyUncorrectable, verifyUncorrectable};
			eraseAt = 'x;
			wd = 'x;
			wr(8'h01, 8'h80);
			n = 0;
			do begin
				@(negedge mclk);
				n++;
				if (arrayErase === 1'b1) eraseAt = arrayAddr;
				if (arrayProgram === 1'b1) wd = arrayWdata;
			end while (commandCompleteFlag !== 1'b1 && n < 2000);
			chkRd(8'h01, st, "status");
			if (st[5] | st[4]) `CHK("reject time", 6, n)
			else if (c == `NVMC_CMD_ERASE) `CHK("sector", a & `NVMC_SECTOR_MASK, eraseAt)
			else `CHK("prog data", {pb[2 * ix], pb[2 * ix + 1]}, wd)
			`CHK("irq", 1'b1, irq)
			if (i == 0) begin
				wr(8'h04, 8'h00);
				repeat (2) @(negedge mclk);
				`CHK("irq masked", 1'b0, irq)
				wr(8'h04, 8'h07);
			end
			chkRd(8'h03, {5'h00, st[4], st[5], 1'b1}, "int status");
			`CHK("irq cleared", 1'b0, irq)
			wr(8'h01, 8'h30);
		end
		tally_and_finish();
	end
endmodule // nvmc_top_tb
